// [rtl/krsc_control.sv]
/*
 * backplane sequencer control register with its management slave port.
 * assumes word-addressed single-cycle reads and writes, read data one cycle later,
 * and a sequencer, pcs reconfiguration and fec logic that use the control outputs.
 */
// Overview of operation
// - writing restart resets sequencer, starts reconfiguration, maybe restarts negotiation/training
// - restart bit clears itself; software never writes zero
// - negotiation timer bit high stops the negotiation disable timer
// - link fail timer bit high disables the link fail timer
// - error policy bit high makes non-zero training error a failure
// - four-bit force field selects a protocol by fixed codes
// - calibration bit high runs calibration during reconfiguration, else skipped
// - training failure: action bit high enters data mode, else renegotiate/retrain
// - fec enable bit switches fec; resets to build-time capability
// - fec error report bit gates decoding errors to the pcs
// - every register resets to zero unless the field says otherwise
// - four-lane offsets sit a fixed distance above single-lane ones
// - phy registers occupy the internal block, a lower core range
// - all registers reached through one management slave address space
// - training and fec controls apply to lane 0
module krsc_control #(
	parameter bit fec_capable_param = 1'b0 // build-time fec capability
) (
	input wire logic clock, // 20 MHz system clock
	input wire logic rstn, // async reset, active low
	input wire logic [10:0] address, // word address, internal offset
	input wire logic write, // write strobe
	input wire logic read, // read strobe
	input wire logic [31:0] writedata, // write data
	output logic [31:0] readdata, // read data, one cycle after read
	output logic sequencer_restart, // one-cycle restart pulse
	output logic [3:0] protocol_force_select, // force code in effect
	output logic negotiation_timer_off, // stop negotiation disable timer
	output logic link_fail_timer_off, // stop link fail timer
	output logic training_error_is_failure, // error means training failed
	output logic calibration_on, // run calibration on reconfiguration
	output logic training_fail_action, // 1 data mode, 0 renegotiate or retrain
	output logic fec_on, // lane 0 fec enabled
	output logic fec_error_report_on, // lane 0 fec errors to pcs
	output logic fec_request // lane 0 fec requested in negotiation
);
	localparam logic [31:0] CTRL_INIT = krsc_pkg::CTRL_RESET |
		(32'(fec_capable_param) << krsc_pkg::BIT_FEC_ON);

	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic hit_ctrl;
	logic fire;
	logic [3:0] force_live;

	// ==========================================================
	// decode
	function automatic logic is_ctrl(input logic [10:0] a);
		return a == krsc_pkg::ADDR_CONTROL;
	endfunction

	assign hit_ctrl = is_ctrl(address);
	assign fire = write && hit_ctrl && writedata[krsc_pkg::BIT_RESTART];
	// the restart takes the force code of its own write, so one write can set and apply it
	assign next_ctrl = (write && hit_ctrl) ?
		(writedata & krsc_pkg::CTRL_WMASK & ~(32'h1 << krsc_pkg::BIT_RESTART)) : ctrl;

	// ==========================================================
	// register storage; restart bit is never stored so it always reads zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl <= CTRL_INIT;
		end else if (write && hit_ctrl) begin
			// other addresses are ignored: no side effect from stray writes
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			readdata <= 32'h0;
		end else if (read) begin
			readdata <= hit_ctrl ? ctrl : 32'h0;
		end
	end

	krsc_restart u_restart (
		.clock(clock),
		.rstn(rstn),
		.fire(fire),
		.force_reg(next_ctrl[krsc_pkg::FORCE_MSB:krsc_pkg::FORCE_LSB]),
		.pulse(sequencer_restart),
		.force_live(force_live)
	);

	// ==========================================================
	// control outputs, registered
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			protocol_force_select <= krsc_pkg::KRSC_FORCE_NONE;
			negotiation_timer_off <= 1'b0;
			link_fail_timer_off <= 1'b0;
			training_error_is_failure <= 1'b0;
			calibration_on <= 1'b0;
			training_fail_action <= 1'b0;
		end else begin
			protocol_force_select <= force_live;
			negotiation_timer_off <= ctrl[krsc_pkg::BIT_AN_TMR_OFF];
			link_fail_timer_off <= ctrl[krsc_pkg::BIT_LF_TMR_OFF];
			training_error_is_failure <= ctrl[krsc_pkg::BIT_ERR_FAIL];
			calibration_on <= ctrl[krsc_pkg::BIT_CAL_ON];
			training_fail_action <= ctrl[krsc_pkg::BIT_FAIL_ACT];
		end
	end

	// fec controls drive lane 0 only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fec_on <= fec_capable_param;
			fec_error_report_on <= 1'b0;
			fec_request <= 1'b0;
		end else begin
			fec_on <= ctrl[krsc_pkg::BIT_FEC_ON];
			fec_error_report_on <= ctrl[krsc_pkg::BIT_FEC_ERR];
			fec_request <= ctrl[krsc_pkg::BIT_FEC_REQ];
		end
	end

	// ==========================================================
	// assertions
	property p_restart_pulse;
		@(posedge clock) disable iff (!rstn)
		fire |=> sequencer_restart;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart missing");

	property p_restart_single;
		@(posedge clock) disable iff (!rstn)
		sequencer_restart |-> $past(fire);
	endproperty
	a_restart_single: assert property (p_restart_single) else $error("restart too long");

	property p_restart_reads_zero;
		@(posedge clock) disable iff (!rstn)
		read |=> !readdata[krsc_pkg::BIT_RESTART];
	endproperty
	a_restart_reads_zero: assert property (p_restart_reads_zero) else $error("restart read 1");

	property p_an_timer;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			negotiation_timer_off == $past(writedata[krsc_pkg::BIT_AN_TMR_OFF], 2);
	endproperty
	a_an_timer: assert property (p_an_timer) else $error("an timer bit wrong");

	property p_lf_timer;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			link_fail_timer_off == $past(writedata[krsc_pkg::BIT_LF_TMR_OFF], 2);
	endproperty
	a_lf_timer: assert property (p_lf_timer) else $error("lf timer bit wrong");

	property p_force_hold;
		@(posedge clock) disable iff (!rstn)
		!fire ##1 !fire |=> $stable(protocol_force_select);
	endproperty
	a_force_hold: assert property (p_force_hold) else $error("force moved without restart");

	property p_force_take;
		@(posedge clock) disable iff (!rstn)
		fire |=> ##1 protocol_force_select ==
			$past(writedata[krsc_pkg::FORCE_MSB:krsc_pkg::FORCE_LSB], 2);
	endproperty
	a_force_take: assert property (p_force_take) else $error("force not taken");

	property p_fec_read;
		@(posedge clock) disable iff (!rstn)
		read && hit_ctrl |=> readdata[krsc_pkg::BIT_FEC_ON] == fec_on;
	endproperty
	a_fec_read: assert property (p_fec_read) else $error("fec readback mismatch");

	property p_unmapped;
		@(posedge clock) disable iff (!rstn)
		read && !hit_ctrl |=> readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_err_fail;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			training_error_is_failure == $past(writedata[krsc_pkg::BIT_ERR_FAIL], 2);
	endproperty
	a_err_fail: assert property (p_err_fail) else $error("error policy bit wrong");

	property p_cal_on;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			calibration_on == $past(writedata[krsc_pkg::BIT_CAL_ON], 2);
	endproperty
	a_cal_on: assert property (p_cal_on) else $error("calibration bit wrong");

	property p_fail_act;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			training_fail_action == $past(writedata[krsc_pkg::BIT_FAIL_ACT], 2);
	endproperty
	a_fail_act: assert property (p_fail_act) else $error("fail action bit wrong");

	property p_fec_on;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			fec_on == $past(writedata[krsc_pkg::BIT_FEC_ON], 2);
	endproperty
	a_fec_on: assert property (p_fec_on) else $error("fec enable bit wrong");

	property p_fec_err;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			fec_error_report_on == $past(writedata[krsc_pkg::BIT_FEC_ERR], 2);
	endproperty
	a_fec_err: assert property (p_fec_err) else $error("fec error report bit wrong");

	property p_fec_req;
		@(posedge clock) disable iff (!rstn)
		write && hit_ctrl ##1 !(write && hit_ctrl) |=>
			fec_request == $past(writedata[krsc_pkg::BIT_FEC_REQ], 2);
	endproperty
	a_fec_req: assert property (p_fec_req) else $error("fec request bit wrong");

	c_restart: cover property (@(posedge clock) disable iff (!rstn) sequencer_restart);
	c_fec_req: cover property (@(posedge clock) disable iff (!rstn) fec_request);
	c_force_kr: cover property (@(posedge clock) disable iff (!rstn)
		protocol_force_select == krsc_pkg::KRSC_FORCE_KRFEC);
	c_fail_act: cover property (@(posedge clock) disable iff (!rstn) training_fail_action);
endmodule

// [rtl/krsc_pkg.sv]
/*
 * package for the backplane sequencer control register: word address, field positions,
 * force codes and reset values.
 * assumes a word-addressed management port whose addresses are the internal offsets.
 */
package krsc_pkg;
	// ==========================================================
	// address map
	localparam logic [10:0] ADDR_CONTROL = 11'h4b0;
	localparam logic [10:0] KR_BLOCK_LO = 11'h4b0;
	localparam logic [10:0] KR_BLOCK_HI = 11'h4ff;
	localparam logic [10:0] QUAD_SHIFT = 11'h400;
	// ==========================================================
	// field positions
	localparam int BIT_RESTART = 0;
	localparam int BIT_AN_TMR_OFF = 1;
	localparam int BIT_LF_TMR_OFF = 2;
	localparam int BIT_ERR_FAIL = 3;
	localparam int FORCE_LSB = 4;
	localparam int FORCE_MSB = 7;
	localparam int BIT_CAL_ON = 8;
	localparam int BIT_FAIL_ACT = 12;
	localparam int BIT_FEC_ON = 16;
	localparam int BIT_FEC_ERR = 17;
	localparam int BIT_FEC_REQ = 18;
	// writable bits; the rest read as zero
	localparam logic [31:0] CTRL_WMASK = 32'h0007_11ff;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ==========================================================
	// protocol force codes
	typedef enum logic [3:0] {
		KRSC_FORCE_NONE = 4'h0,
		KRSC_FORCE_GIGE = 4'h1,
		KRSC_FORCE_XAUI = 4'h2,
		KRSC_FORCE_10GR = 4'h4,
		KRSC_FORCE_10GKR = 4'h5,
		KRSC_FORCE_KRFEC = 4'hc
	} krsc_force_t;
	// ==========================================================
	// sequencer restart one-hot states
	typedef enum logic [1:0] {
		KRSC_IDLE = 2'b01,
		KRSC_PULSE = 2'b10
	} krsc_state_t;
endpackage

// [rtl/krsc_restart.sv]
/*
 * restart pulse generator: turns a write of the restart bit into one cycle of restart,
 * capturing the force code that applies from that restart onward.
 * assumes the write strobe is synchronous to clock.
 */
module krsc_restart (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic fire, // restart bit written as 1
	input wire logic [3:0] force_reg, // force field as it is being stored
	output logic pulse, // one-cycle restart
	output logic [3:0] force_live // force code in effect
);
	krsc_pkg::krsc_state_t state;

	// ==========================================================
	// state machine
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= krsc_pkg::KRSC_IDLE;
		end else begin
			case (state)
				krsc_pkg::KRSC_IDLE: begin
					if (fire) begin
						state <= krsc_pkg::KRSC_PULSE;
					end
				end
				krsc_pkg::KRSC_PULSE: begin
					state <= fire ? krsc_pkg::KRSC_PULSE : krsc_pkg::KRSC_IDLE;
				end
				default: begin
					state <= krsc_pkg::KRSC_IDLE;
				end
			endcase
		end
	end

	// the pulse is a decode of the state register, so the two cannot drift apart
	assign pulse = (state == krsc_pkg::KRSC_PULSE);

	// a changed force code is held back until the restart, as the sequencer expects
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			force_live <= krsc_pkg::KRSC_FORCE_NONE;
		end else if (fire) begin
			force_live <= force_reg;
		end
	end
endmodule

// [verif/krsc_seq_model.sv]
/*
 * sequencer stand-in on the far side of the control register: counts restart
 * cycles and adopts the forced protocol only when it is restarted.
 * assumes the register drives restart and force code from the same clock.
 */
module krsc_seq_model (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic sequencer_restart, // restart pulse from the register
	input wire logic [3:0] protocol_force_select, // force code in effect
	output logic [15:0] restarts, // restart cycles seen, kept across resets
	output logic [3:0] mode // protocol the sequencer runs
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend;
	initial restarts = 16'h0000;
	// ==========================================================
	// restart handling
	always @(posedge clock) begin
		if (rstn && sequencer_restart) begin
			restarts <= restarts + 16'h0001;
		end
	end
	// force code is read one cycle after restart, when it has settled
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pend <= 1'b0;
			mode <= 4'h0;
		end else begin
			pend <= sequencer_restart;
			if (pend) begin
				mode <= protocol_force_select;
			end
		end
	end
endmodule

// [verif/krsc_control_bench.sv]
/*
 * self-checking bench for the sequencer control register.
 * assumes the register sits at krsc_pkg::ADDR_CONTROL, fec capability set to 1.
 */
module krsc_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [10:0] address = 11'h000;
	logic write = 1'b0;
	logic read = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic sequencer_restart;
	logic [3:0] protocol_force_select;
	logic [7:0] lv;
	logic [15:0] restarts;
	logic [3:0] mode;
	int mismatches = 0;
	int check_count = 0;
	logic [31:0] q[$];
	logic took = 1'b0;
	logic [31:0] seed = 32'h5f49;
	logic [31:0] r;
	logic [3:0] ef;
	logic [15:0] er = 16'h0000;
	logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hc};
	krsc_control #(.fec_capable_param(1'b1)) uut (.clock(clock), .rstn(rstn),
		.address(address), .write(write), .read(read), .writedata(writedata),
		.readdata(readdata), .sequencer_restart(sequencer_restart),
		.protocol_force_select(protocol_force_select), .negotiation_timer_off(lv[0]),
		.link_fail_timer_off(lv[1]), .training_error_is_failure(lv[2]),
		.calibration_on(lv[3]), .training_fail_action(lv[4]), .fec_on(lv[5]),
		.fec_error_report_on(lv[6]), .fec_request(lv[7]));
	krsc_seq_model partner (.clock(clock), .rstn(rstn), .sequencer_restart(sequencer_restart),
		.protocol_force_select(protocol_force_select), .restarts(restarts), .mode(mode));
	always #25 clock = ~clock;
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		if (a == krsc_pkg::ADDR_CONTROL) begin
			r = d & krsc_pkg::CTRL_WMASK & 32'hffff_fffe;
			if (d[0]) begin
				ef = d[7:4];
				er++;
			end
		end
		@(posedge clock);
		write <= 1'b0;
	endtask
	task automatic rd(input logic [10:0] a, input logic [31:0] e);
		@(posedge clock);
		address <= a;
		read <= 1'b1;
		q.push_back(e);
		@(posedge clock);
		read <= 1'b0;
		@(negedge clock);
	endtask
	// levels, force and restart count land two edges after the write, the mode one edge later
	task automatic check_all();
		@(posedge clock);
		@(negedge clock);
		chk("levels", {24'h0, lv}, {24'h0, r[18], r[17], r[16], r[12], r[8], r[3:1]});
		chk("force", {28'h0, protocol_force_select}, {28'h0, ef});
		chk("restarts", {16'h0, restarts}, {16'h0, er});
		rd(krsc_pkg::ADDR_CONTROL, r);
		chk("mode", {28'h0, mode}, {28'h0, ef});
	endtask
	// ==========================================================
	// read result watcher
	always @(posedge clock) took <= read & rstn;
	always @(negedge clock) begin
		if (took) begin
			if (q.size() == 0) begin
				chk("queue", 32'h1, 32'h0);
			end else begin
				chk("readdata", readdata, q.pop_front());
			end
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		stop_test();
	end
	initial begin
		r = 32'h0001_0000;
		ef = 4'h0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		check_all();
		wr(krsc_pkg::ADDR_CONTROL, 32'h0000_00c1);
		check_all();
		foreach (codes[i]) begin
			wr(krsc_pkg::ADDR_CONTROL, {24'h0, codes[i], 4'h0});
			check_all();
			wr(krsc_pkg::ADDR_CONTROL, {24'h0, codes[i], 4'h1});
			check_all();
		end
		repeat (12) begin
			seed = lfsr(seed);
			wr(krsc_pkg::ADDR_CONTROL, seed | 32'h0000_0001);
			check_all();
		end
		wr(11'h4b1, ~r);
		check_all();
		rd(11'h4b1, 32'h0000_0000);
		rd(krsc_pkg::ADDR_CONTROL - krsc_pkg::QUAD_SHIFT, 32'h0000_0000);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		r = 32'h0001_0000;
		ef = 4'h0;
		check_all();
		repeat (4) @(posedge clock);
		stop_test();
	end
endmodule
